//--- common/pcsu_map.vh
// Constants for the program-counter sequencing unit
`ifndef PCSU_MAP_VH
`define PCSU_MAP_VH
`define PCSU_PC_W        13
`define PCSU_PC_RST      13'h0000
`define PCSU_LOW_MSB     7
`define PCSU_HIGH_LSB    8
`define PCSU_PAGE_LSB    11
`define PCSU_JUMP_W      11
`define PCSU_LATCH_LO    4
`define PCSU_LATCH_PG_LSB 3
`define PCSU_LATCH_RST   8'h00
`define PCSU_STK_DEPTH   8
`define PCSU_STK_PTR_W   3
`define PCSU_STK_PTR_RST 3'h0
`define PCSU_ADDR_W      9
`define PCSU_BANK_BIT    8
`define PCSU_IND_PORT    7'h00
`define PCSU_DIR_W       7
`define PCSU_ZERO_BYTE   8'h00
`define PCSU_FSR_RST     8'h00
`endif

//--- logic/pcsu_core.v
// Program counter, return stack and indirect data addressing
// What this block does
// - Program counter is 13 bits; low byte is a readable, writable register.
// - Upper counter bits are never directly accessed; they load from the latch, a stack pop, the interrupt vector or an increment carry.
// - Any reset clears the whole program counter.
// - Low-byte write loads low byte and copies latch bits 4..0 to bits 12..8.
// - Call and jump take the low 11 counter bits from the instruction.
// - Call and jump take counter bits 12..11 from latch bits 4..3.
// - Adding to the low byte acts as a computed jump within 256 words.
// - Eight-entry 13-bit return stack, outside memory, pointer hidden from software.
// - Calls and interrupt vectoring push the program counter.
// - Return, return_with_literal and return_from_interrupt pop all 13 bits.
// - Pushes and pops leave the high latch unchanged.
// - Stack wraps circularly; ninth push overwrites the first entry.
// - No overflow or underflow status is provided.
// - Program space is 8K words in four 2K pages.
// - The indirect port has no storage; it accesses the pointed location.
// - Indirect read of the indirect port itself returns zero.
// - Indirect write to the indirect port itself stores nothing.
// - Indirect address is 9 bits from the 8-bit pointer and bank bit.
`timescale 1ns/100ps
`include "pcsu_map.vh"

module pcsu_core (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_b,
  // Sequencing requests from the decoder, one cycle each
  input  wire        inc_req,
  input  wire        low_wr,
  input  wire [7:0]  low_wr_data,
  input  wire        jump_req,
  input  wire        call_req,
  input  wire [10:0] jump_target,
  input  wire        int_req,
  input  wire [12:0] int_vector,
  input  wire        ret_req,
  // High latch and pointer writes
  input  wire        latch_wr,
  input  wire [7:0]  latch_wr_data,
  input  wire        ptr_wr,
  input  wire [7:0]  ptr_wr_data,
  input  wire        indirect_bank_bit,
  // Data-space access from the decoder
  input  wire [6:0]  dir_addr,
  input  wire        dir_bank,
  input  wire        data_wr_req,
  input  wire [7:0]  ram_rd_data,
  // Program counter view
  output reg  [12:0] pc_ff,
  output reg  [7:0]  pc_high_latch_ff,
  output reg  [7:0]  file_select_pointer_ff,
  output wire [7:0]  pc_low_byte,
  // Data-space address and gated data
  output wire [8:0]  data_addr,
  output wire        data_wr_en,
  output wire [7:0]  data_rd_data
);

  // Sources for the next program counter, one code per sequencing action; call and jump share SRC_PAGE
  localparam [2:0] SRC_HOLD = 3'h0;
  localparam [2:0] SRC_INC  = 3'h1;
  localparam [2:0] SRC_LOW  = 3'h2;
  localparam [2:0] SRC_PAGE = 3'h3;
  localparam [2:0] SRC_POP  = 3'h4;
  localparam [2:0] SRC_VEC  = 3'h5;

  // Return stack storage and its hidden pointer; neither is mapped anywhere
  reg  [12:0] stack_ff [0:`PCSU_STK_DEPTH-1];
  reg  [2:0]  sp_ff;

  // Action chosen for this cycle
  reg  [2:0]  pc_src;
  reg         do_push;
  reg         do_pop;

  // Next-state values
  reg  [12:0] nxt_pc;
  reg  [2:0]  nxt_sp;
  reg  [12:0] push_data;
  reg  [7:0]  nxt_pc_high_latch;
  reg  [7:0]  nxt_file_select_pointer;

  // Candidate counter values and stack views
  wire [12:0] pc_plus;
  wire [12:0] page_addr;
  wire [12:0] low_addr;
  wire [2:0]  sp_up;
  wire [2:0]  sp_down;
  wire [12:0] pop_data;

  // Data-space decode
  wire        ind_sel;
  wire        self_ptr;
  wire        null_access;
  wire [8:0]  ind_addr;
  wire [8:0]  dir_full_addr;

  // Loop index for clearing the stack under reset
  integer     i;

  // Direct field or pointer naming the indirect port; both decodes share it
  function is_ind_port;
    input [6:0] a;
    begin
      is_ind_port = (a == `PCSU_IND_PORT);
    end
  endfunction

  // One circular step of the stack pointer; the wrap is silent
  function [2:0] sp_step;
    input [2:0] p;
    input       up;
    begin
      if (up) begin
        sp_step = p + 3'h1;
      end else begin
        sp_step = p - 3'h1;
      end
    end
  endfunction

  // High counter bits come only from the latch: a page pair or the full high part
  function [12:0] load_addr;
    input [7:0]  latch;
    input [10:0] low_part;
    input        page;
    begin
      if (page) begin
        load_addr = {latch[`PCSU_LATCH_LO:`PCSU_LATCH_PG_LSB], low_part};
      end else begin
        load_addr = {latch[`PCSU_LATCH_LO:0], low_part[`PCSU_LOW_MSB:0]};
      end
    end
  endfunction

  // Plain step; a carry out of bit 12 wraps to zero
  assign pc_plus = pc_ff + 13'h0001;

  // Page-relative target for call and jump
  assign page_addr = load_addr(pc_high_latch_ff, jump_target, 1'b1);

  // An add result lands here too, with no carry into the high bits
  assign low_addr = load_addr(pc_high_latch_ff, {3'h0, low_wr_data}, 1'b0);

  // Neighbouring pointer values and the entry a pop would restore
  assign sp_up    = sp_step(sp_ff, 1'b1);
  assign sp_down  = sp_step(sp_ff, 1'b0);
  assign pop_data = stack_ff[sp_down];

  // Low byte seen by software; the high bits have no read path
  assign pc_low_byte = pc_ff[`PCSU_LOW_MSB:0];

  // Priority: interrupt, return, call or jump, low write, increment; the rest is dropped
  always @* begin
    pc_src  = SRC_HOLD;
    do_push = 1'b0;
    do_pop  = 1'b0;
    if (int_req) begin
      pc_src  = SRC_VEC;
      do_push = 1'b1;
    end else if (ret_req) begin
      pc_src = SRC_POP;
      do_pop = 1'b1;
    end else if (call_req | jump_req) begin
      pc_src  = SRC_PAGE;
      do_push = call_req;
    end else if (low_wr) begin
      pc_src = SRC_LOW;
    end else if (inc_req) begin
      pc_src = SRC_INC;
    end
  end

  // Next program counter from the chosen source
  always @* begin
    case (pc_src)
      SRC_INC: begin
        nxt_pc = pc_plus;
      end
      SRC_LOW: begin
        nxt_pc = low_addr;
      end
      SRC_PAGE: begin
        nxt_pc = page_addr;
      end
      SRC_POP: begin
        nxt_pc = pop_data; // All 13 bits come back
      end
      SRC_VEC: begin
        nxt_pc = int_vector;
      end
      SRC_HOLD: begin
        nxt_pc = pc_ff;
      end
      default: begin
        nxt_pc = pc_ff;
      end
    endcase
  end

  // An interrupt saves the instruction not yet run; a call saves the one after it
  always @* begin
    if (int_req) begin
      push_data = pc_ff;
    end else begin
      push_data = pc_plus;
    end
  end

  // Pointer moves up on a push, down on a pop; overflow and underflow wrap
  always @* begin
    nxt_sp = sp_ff;
    if (do_push) begin
      nxt_sp = sp_up;
    end else if (do_pop) begin
      nxt_sp = sp_down;
    end
  end

  // Latch follows its own write only; pushes and pops never touch it
  always @* begin
    nxt_pc_high_latch = pc_high_latch_ff;
    if (latch_wr) begin
      nxt_pc_high_latch = latch_wr_data;
    end
  end

  // Pointer follows its own write only
  always @* begin
    nxt_file_select_pointer = file_select_pointer_ff;
    if (ptr_wr) begin
      nxt_file_select_pointer = ptr_wr_data;
    end
  end

  // Program counter; every reset clears all of it
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_ff <= `PCSU_PC_RST;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // Stack pointer, invisible to software
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_ff <= `PCSU_STK_PTR_RST;
    end else begin
      sp_ff <= nxt_sp;
    end
  end

  // Stack entries; a ninth push lands on the oldest slot
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < `PCSU_STK_DEPTH; i = i + 1) begin
        stack_ff[i] <= `PCSU_PC_RST;
      end
    end else if (do_push) begin
      stack_ff[sp_ff] <= push_data;
    end
  end

  // High latch register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_high_latch_ff <= `PCSU_LATCH_RST;
    end else begin
      pc_high_latch_ff <= nxt_pc_high_latch;
    end
  end

  // Pointer register
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      file_select_pointer_ff <= `PCSU_FSR_RST;
    end else begin
      file_select_pointer_ff <= nxt_file_select_pointer;
    end
  end

  // Indirect access when the direct field names the indirect port
  assign ind_sel  = is_ind_port(dir_addr);
  assign self_ptr = is_ind_port(file_select_pointer_ff[`PCSU_DIR_W-1:0]);

  // A pointer back onto the port itself reads zero and stores nothing
  assign null_access = ind_sel & self_ptr;

  // Bank bit on top, pointer below
  assign ind_addr      = {indirect_bank_bit, file_select_pointer_ff};
  assign dir_full_addr = {1'b0, dir_bank, dir_addr};

  // Combinational so the data memory sees the address in the same cycle
  assign data_addr = ind_sel ? ind_addr : dir_full_addr;

  // Status flags stay with the decoder; only the store is suppressed
  assign data_wr_en   = data_wr_req & ~null_access;
  assign data_rd_data = null_access ? `PCSU_ZERO_BYTE : ram_rd_data;

endmodule

//--- verif/pcsu_ram_mdl.sv
// Data memory stand-in for the data-space port
`timescale 1ns/100ps
module pcsu_ram_mdl (
  input wire [8:0] data_addr,
  output wire [7:0] ram_rd_data
);
  // Content scrambles the address, so a wrong address shows in the data
  assign ram_rd_data = data_addr[7:0] ^ {data_addr[8], 7'h25};
endmodule

//--- verif/pcsu_chk.sv
// Assertion checker for the sequencing unit
`timescale 1ns/100ps
module pcsu_chk (
  input wire sys_clk, rst_b, inc_req, low_wr, jump_req, call_req, int_req, ret_req, latch_wr,
  input wire indirect_bank_bit, data_wr_en, input wire [6:0] dir_addr, input wire [8:0] data_addr,
  input wire [7:0] low_wr_data, pc_high_latch_ff, file_select_pointer_ff, data_rd_data,
  input wire [10:0] jump_target, input wire [12:0] int_vector, pc_ff);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Higher-priority requests hide lower ones in the same cycle
  wire hi = int_req | ret_req;
  wire lo = hi | jump_req | call_req;
  wire ia = dir_addr == 7'h00;
  sequence s_call; call_req && !hi; endsequence
  sequence s_gap; !lo; endsequence
  a_jump_page: assert property ((jump_req | call_req) && !hi |=>
    pc_ff == {$past(pc_high_latch_ff[4:3]), $past(jump_target)}) else $error("jump");
  a_low_load: assert property (low_wr && !lo |=>
    pc_ff == {$past(pc_high_latch_ff[4:0]), $past(low_wr_data)}) else $error("low");
  a_inc_step: assert property (inc_req && !lo && !low_wr |=>
    pc_ff == $past(pc_ff) + 13'h1) else $error("inc");
  a_int_vec: assert property (int_req |=> pc_ff == $past(int_vector)) else $error("int");
  a_call_ret: assert property (s_call ##1 s_gap ##1 ret_req && !int_req |=>
    pc_ff == $past(pc_ff, 3) + 13'h1) else $error("ret");
  a_latch_hold: assert property (!latch_wr |=> $stable(pc_high_latch_ff))
    else $error("latch");
  a_ind_addr: assert property (ia |->
    data_addr == {indirect_bank_bit, file_select_pointer_ff}) else $error("addr");
  a_ind_null: assert property (ia && file_select_pointer_ff[6:0] == 7'h00 |->
    data_rd_data == 8'h00 && !data_wr_en) else $error("null");
endmodule
bind pcsu_core pcsu_chk chk_u (.*);

//--- verif/pcsu_core_tb.sv
// Random bench for the sequencing unit
`timescale 1ns/100ps
module pcsu_core_tb;
  logic sys_clk = '0, rst_b = '0, inc_req = '0, low_wr = '0, jump_req = '0, call_req = '0;
  logic int_req = '0, ret_req = '0, latch_wr = '0, ptr_wr = '0, indirect_bank_bit = '0;
  logic dir_bank = '0, data_wr_req = '0, data_wr_en, z;
  logic [6:0] dir_addr = '0;
  logic [7:0] low_wr_data = '0, latch_wr_data = '0, ptr_wr_data = '0, l, pc_low_byte;
  logic [7:0] pc_high_latch_ff, file_select_pointer_ff, ram_rd_data, data_rd_data;
  logic [8:0] data_addr, d;
  logic [10:0] jump_target = '0;
  logic [12:0] int_vector = '0, pc_ff, e, s [8];
  logic [2:0] p;
  int bad_count = 0, checks = 0, cyc = 0, i;
  pcsu_core dut_u (.*);
  pcsu_ram_mdl ram_u (.*);
  initial forever #20 sys_clk = ~sys_clk;
  task chk_pc(logic [28:0] g, x);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %0t pc got %h want %h", $time, g, x);
    end
  endtask
  task chk_data(logic [25:0] g, x);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %0t data got %h want %h", $time, g, x);
    end
  endtask
  // Word the memory stand-in returns for an address
  function logic [7:0] ram_word(logic [8:0] a);
    return a[7:0] ^ {a[8], 7'h25};
  endfunction
  // One decoder request; pc, latch and a circular stack are tracked beside it
  task op(int k, logic [12:0] v);
    @(posedge sys_clk);
    {latch_wr, ret_req, int_req, call_req, jump_req, low_wr, inc_req} <=
      k == 7 ? 7'h1d : 7'h01 << k; // Seven: interrupt beside call, jump and step
    {low_wr_data, latch_wr_data, jump_target, int_vector} <= {v[7:0], v[7:0], v[10:0], v};
    @(posedge sys_clk);
    {latch_wr, ret_req, int_req, call_req, jump_req, low_wr, inc_req} <= 7'h00;
    if (k == 3 || k == 4 || k == 7) s[p++] = k == 3 ? e + 13'h1 : e;
    case (k)
      0: e = e + 13'h1;
      1: e = {l[4:0], v[7:0]};
      4, 7: e = v;
      5: e = s[--p];
      6: l = v[7:0];
      default: e = {l[4:3], v[10:0]};
    endcase
    #1 chk_pc({pc_high_latch_ff, pc_low_byte, pc_ff},
      {l, e[7:0], e});
  endtask
  // Indirect access; the self-pointer case must read zero and write nothing
  task ind(logic [7:0] q, logic b, logic [6:0] a);
    @(posedge sys_clk);
    {ptr_wr, ptr_wr_data, indirect_bank_bit, dir_addr, dir_bank, data_wr_req} <= {1'b1, q, b, a, ~b, 1'b1};
    @(posedge sys_clk);
    ptr_wr <= 1'b0;
    d = a == 7'h00 ? {b, q} : {1'b0, ~b, a};
    z = a == 7'h00 && q[6:0] == 7'h00;
    #1 chk_data({file_select_pointer_ff, data_wr_en, data_rd_data, data_addr},
      {q, !z, z ? 8'h00 : ram_word(d), d});
  endtask
  task rs;
    @(posedge sys_clk) rst_b <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    {e, l, p} = '0;
    s = '{default: '0};
    #1 chk_pc({pc_high_latch_ff, pc_low_byte, pc_ff}, 29'h0);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, well above the roughly 800 cycles planned
  always @(posedge sys_clk) if (++cyc == 4000) begin
    bad_count++;
    $display("[FAIL] %0t timeout", $time);
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h6348));
    rs();
    for (i = 0; i < 10; i++) op(3, 13'h0100 + 13'(i));
    for (i = 0; i < 11; i++) op(5, '0);
    $display("stack wrap test done");
    op(6, 13'h001f);
    op(1, 13'h00ff);
    op(0, '0);
    op(7, 13'h0abc);
    for (i = 0; i < 300; i++) op($urandom % 8, 13'($urandom));
    $display("random test done");
    rs();
    for (i = 0; i < 60; i++) ind(i < 4 ? 8'(i << 7) : 8'($urandom), 1'($urandom),
      i % 3 ? 7'h00 : 7'($urandom));
    $display("indirect test done");
    report_and_stop();
  end
endmodule
